// ==== hsa_top.sv ====
// Purpose: Fault and condition flag tree with Wishbone register access.
// Assumes: Leaf inputs come from logic on mclk_i; yaw rate is signed.
// Notes:   Summaries are combinational so they track leaves the same cycle.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.

`default_nettype none

module hsa_top #(
    parameter int LEAK_TICK = hsa_pkg::LEAK_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Fault leaves
    input  wire logic        board_temperature_fault_i,
    input  wire logic [4:0]  user_port_fault_i,
    input  wire logic [4:0]  aiding_port_fault_i,
    input  wire logic [2:0]  navigation_fault_i,
    input  wire logic        cal_checksum_mismatch_i,
    input  wire logic        cal_write_cmd_i,
    input  wire logic        iron_param_fault_i,
    // Condition leaves
    input  wire logic [3:0]  hw_condition_i,
    input  wire logic        external_fix_data_i,
    input  wire logic        navigation_starting_i,
    input  wire logic        gain_level_flag_i,
    input  wire logic        orientation_only_tracking_i,
    input  wire logic [15:0] yaw_rate_i,
    // Neighbouring branches
    input  wire logic        power_fault_summary_i,
    input  wire logic        sensor_condition_summary_i,
    // Summaries
    output logic             environment_fault_summary_o,
    output logic             user_port_fault_summary_o,
    output logic             aiding_port_fault_summary_o,
    output logic             link_fault_flag_o,
    output logic             navigation_fault_summary_o,
    output logic             stored_data_fault_summary_o,
    output logic             program_fault_flag_o,
    output logic             hw_fault_flag_o,
    output logic             hw_condition_summary_o,
    output logic             link_condition_summary_o,
    output logic             program_condition_summary_o,
    output logic             top_alert_flag_o,
    output logic             top_fatal_flag_o,
    output logic             soft_fault_o
);
    import hsa_pkg::*;

    typedef struct packed {
        logic [15:0]      hw_mask;
        logic [15:0]      link_mask;
        logic [15:0]      prog_mask;
        logic [15:0]      yaw_thr;
        logic [CNT_W-1:0] soft_thr;
        logic [CNT_W-1:0] leak_cnt;
        logic [31:0]      div_cnt;
        logic             cal_comp;
        logic             fatal_latch;
        logic             ack;
        logic [31:0]      rdat;
    } hsa_state_t;

    hsa_state_t st_r;
    hsa_state_t st_nxt;

    logic [15:0] env_flags;
    logic [15:0] link_fault;
    logic [15:0] user_flags;
    logic [15:0] aid_flags;
    logic [15:0] prog_fault;
    logic [15:0] nav_flags;
    logic [15:0] data_flags;
    logic [15:0] hw_cond;
    logic [15:0] link_cond;
    logic [15:0] prog_cond;
    logic [15:0] health;
    logic [15:0] yaw_mag;
    logic        yaw_turn;
    logic        hard_fault;
    logic        tick;
    logic        wr_acc;
    logic [31:0] wmask;

    // Leaf fields, reserved bits forced low
    assign env_flags  = {15'h0000, board_temperature_fault_i};
    assign user_flags = {11'h000, user_port_fault_i} & VLD_PORT;
    assign aid_flags  = {11'h000, aiding_port_fault_i} & VLD_PORT;
    assign nav_flags  = {13'h0000, navigation_fault_i} & VLD_NAV;

    always_comb begin
        data_flags = 16'h0000;
        data_flags[BIT_CHECKSUM] = cal_checksum_mismatch_i | st_r.cal_comp;
        data_flags[BIT_IRON] = iron_param_fault_i;
    end

    // Intermediate summaries
    assign environment_fault_summary_o = |(env_flags & VLD_ENV);
    assign user_port_fault_summary_o   = |user_flags;
    assign aiding_port_fault_summary_o = |aid_flags;
    assign navigation_fault_summary_o  = |nav_flags;
    assign stored_data_fault_summary_o = |(data_flags & VLD_DATA);

    always_comb begin
        link_fault = 16'h0000;
        link_fault[BIT_USER_PORT] = user_port_fault_summary_o;
        link_fault[BIT_AID_PORT]  = aiding_port_fault_summary_o;
        prog_fault = 16'h0000;
        prog_fault[BIT_NAV_SUM]  = navigation_fault_summary_o;
        prog_fault[BIT_DATA_SUM] = stored_data_fault_summary_o;
    end

    assign link_fault_flag_o    = |(link_fault & VLD_LINK_FAULT);
    assign program_fault_flag_o = |(prog_fault & VLD_PROG_FAULT);
    assign hw_fault_flag_o = power_fault_summary_i
                           | environment_fault_summary_o;

    // Yaw turn: magnitude of a signed rate against the threshold
    assign yaw_mag  = yaw_rate_i[15] ? 16'(-yaw_rate_i) : yaw_rate_i;
    assign yaw_turn = yaw_mag > st_r.yaw_thr;

    // Condition fields
    always_comb begin
        hw_cond = {12'h000, hw_condition_i} & VLD_HW_COND;
        link_cond = 16'h0000;
        link_cond[BIT_NO_EXT_FIX] = ~external_fix_data_i;
        prog_cond = 16'h0000;
        prog_cond[BIT_STARTING]    = navigation_starting_i;
        prog_cond[BIT_GAIN]        = gain_level_flag_i;
        prog_cond[BIT_ORIENT_ONLY] = orientation_only_tracking_i;
        prog_cond[BIT_YAW_TURN]    = yaw_turn;
    end

    // Masked condition summaries
    assign hw_condition_summary_o   = |(hw_cond & st_r.hw_mask);
    assign link_condition_summary_o = |(link_cond & st_r.link_mask);
    assign program_condition_summary_o = |(prog_cond & st_r.prog_mask);
    assign top_alert_flag_o = hw_condition_summary_o
                            | sensor_condition_summary_i
                            | link_condition_summary_o
                            | program_condition_summary_o;

    // Hard faults are fatal at once; soft ones only via the counter
    assign hard_fault = navigation_fault_summary_o
                      | stored_data_fault_summary_o;
    assign soft_fault_o = hw_fault_flag_o | link_fault_flag_o;
    assign top_fatal_flag_o = hard_fault | st_r.fatal_latch;

    always_comb begin
        health = 16'h0000;
        health[HW_FATAL]     = top_fatal_flag_o;
        health[HW_HWFAULT]   = hw_fault_flag_o;
        health[HW_LINKFAULT] = link_fault_flag_o;
        health[HW_PROGFAULT] = program_fault_flag_o;
        health[HW_ALERT]     = top_alert_flag_o;
        health[HW_HWCOND]    = hw_condition_summary_o;
        health[HW_LINKCOND]  = link_condition_summary_o;
        health[HW_PROGCOND]  = program_condition_summary_o;
        health[HW_SENSCOND]  = sensor_condition_summary_i;
    end

    assign tick   = st_r.div_cnt == 32'(LEAK_TICK - 1);
    assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack;
    assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        st_nxt = st_r;
        // Single-wait-state ack: drops the cycle after it is given
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        st_nxt.rdat = 32'h0000_0000;
        if (wb_cyc_i && wb_stb_i && !st_r.ack && !wb_we_i) begin
            case (wb_adr_i & 8'hFC)
                OFS_ENV_FAULT:  st_nxt.rdat = {16'h0000, env_flags};
                OFS_LINK_FAULT: st_nxt.rdat = {16'h0000, link_fault};
                OFS_USER_FAULT: st_nxt.rdat = {16'h0000, user_flags};
                OFS_AID_FAULT:  st_nxt.rdat = {16'h0000, aid_flags};
                OFS_PROG_FAULT: st_nxt.rdat = {16'h0000, prog_fault};
                OFS_NAV_FAULT:  st_nxt.rdat = {16'h0000, nav_flags};
                OFS_DATA_FAULT: st_nxt.rdat = {16'h0000, data_flags};
                OFS_HW_COND:    st_nxt.rdat = {16'h0000, hw_cond};
                OFS_LINK_COND:  st_nxt.rdat = {16'h0000, link_cond};
                OFS_PROG_COND:  st_nxt.rdat = {16'h0000, prog_cond};
                OFS_HW_MASK:    st_nxt.rdat = {16'h0000, st_r.hw_mask};
                OFS_LINK_MASK:  st_nxt.rdat = {16'h0000, st_r.link_mask};
                OFS_PROG_MASK:  st_nxt.rdat = {16'h0000, st_r.prog_mask};
                OFS_YAW_THR:    st_nxt.rdat = {16'h0000, st_r.yaw_thr};
                OFS_SOFT_THR:   st_nxt.rdat = {24'h000000, st_r.soft_thr};
                OFS_CONTROL:    st_nxt.rdat = {30'h00000000,
                                               st_r.fatal_latch,
                                               st_r.cal_comp};
                OFS_HEALTH:     st_nxt.rdat = {16'h0000, health};
                default:        st_nxt.rdat = 32'h0000_0000;
            endcase
        end
        if (wr_acc) begin
            case (wb_adr_i & 8'hFC)
                OFS_HW_MASK: st_nxt.hw_mask = VLD_HW_COND &
                    ((st_r.hw_mask & ~wmask[15:0])
                     | (wb_dat_i[15:0] & wmask[15:0]));
                OFS_LINK_MASK: st_nxt.link_mask = VLD_LINK_COND &
                    ((st_r.link_mask & ~wmask[15:0])
                     | (wb_dat_i[15:0] & wmask[15:0]));
                OFS_PROG_MASK: st_nxt.prog_mask = VLD_PROG_COND &
                    ((st_r.prog_mask & ~wmask[15:0])
                     | (wb_dat_i[15:0] & wmask[15:0]));
                OFS_YAW_THR: st_nxt.yaw_thr =
                    (st_r.yaw_thr & ~wmask[15:0])
                    | (wb_dat_i[15:0] & wmask[15:0]);
                OFS_SOFT_THR: begin
                    if (wb_sel_i[0]) begin
                        st_nxt.soft_thr = wb_dat_i[CNT_W-1:0];
                    end
                end
                OFS_CONTROL: begin
                    // Write one to clear; a new set below still wins
                    if (wb_sel_i[0] && wb_dat_i[BIT_CLR_CAL]) begin
                        st_nxt.cal_comp = 1'b0;
                    end
                    if (wb_sel_i[0] && wb_dat_i[BIT_CLR_FATAL]) begin
                        st_nxt.fatal_latch = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Calibration write command marks the stored data suspect
        if (cal_write_cmd_i) begin
            st_nxt.cal_comp = 1'b1;
        end
        // Leaky counter: climbs while soft faults persist, drains otherwise
        st_nxt.div_cnt = tick ? 32'h0000_0000 : st_r.div_cnt + 32'h1;
        if (tick) begin
            if (soft_fault_o) begin
                st_nxt.leak_cnt = (st_r.leak_cnt > CNT_MAX - SOFT_STEP)
                                ? CNT_MAX
                                : st_r.leak_cnt + SOFT_STEP;
            end else if (st_r.leak_cnt != '0) begin
                st_nxt.leak_cnt = st_r.leak_cnt - 8'h01;
            end
        end
        // Zero threshold disables escalation
        if (st_r.soft_thr != '0 && st_r.leak_cnt >= st_r.soft_thr) begin
            st_nxt.fatal_latch = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.hw_mask     <= RST_HW_MASK;
            st_r.link_mask   <= RST_LINK_MASK;
            st_r.prog_mask   <= RST_PROG_MASK;
            st_r.yaw_thr     <= RST_YAW_THR;
            st_r.soft_thr    <= RST_SOFT_THR;
            st_r.leak_cnt    <= '0;
            st_r.div_cnt     <= 32'h0000_0000;
            st_r.cal_comp    <= 1'b0;
            st_r.fatal_latch <= 1'b0;
            st_r.ack         <= 1'b0;
            st_r.rdat        <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdat;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_hw_mask_wr;
        wr_acc && (wb_adr_i & 8'hFC) == OFS_HW_MASK && wb_sel_i[0];
    endsequence

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    AST_ENV_SUM: assert property (
        environment_fault_summary_o == board_temperature_fault_i)
        else $error("environment summary wrong");

    AST_USER_SUM: assert property (
        user_port_fault_summary_o == (user_port_fault_i != 5'h00))
        else $error("user port summary wrong");

    AST_LINK_FLAG: assert property (
        link_fault_flag_o == ((user_port_fault_i != 5'h00)
                              || (aiding_port_fault_i != 5'h00)))
        else $error("link fault flag wrong");

    AST_PROG_FLAG: assert property (
        program_fault_flag_o == ((navigation_fault_i != 3'h0)
            || cal_checksum_mismatch_i || iron_param_fault_i
            || st_r.cal_comp))
        else $error("program fault flag wrong");

    AST_HW_COND: assert property (
        hw_condition_summary_o == ((hw_condition_i & st_r.hw_mask[3:0])
                                   != 4'h0))
        else $error("hardware condition summary wrong");

    AST_MASK_WR: assert property (
        s_hw_mask_wr |=> st_r.hw_mask[7:0] == ($past(wb_dat_i[7:0]) & 8'h0F))
        else $error("hardware mask write wrong");

    AST_HARD_FATAL: assert property (
        (navigation_fault_i != 3'h0 || iron_param_fault_i)
        |-> top_fatal_flag_o)
        else $error("hard fault not fatal");

    AST_CAL_WR: assert property (
        cal_write_cmd_i |=> stored_data_fault_summary_o [*2])
        else $error("calibration write not flagged");

    AST_ACK: assert property (
        s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack timing wrong");

    AST_YAW: assert property (
        (yaw_mag <= st_r.yaw_thr) |-> !prog_cond[BIT_YAW_TURN])
        else $error("yaw turn set below threshold");

    AST_ALERT: assert property (
        sensor_condition_summary_i |-> top_alert_flag_o)
        else $error("alert missing sensor summary");

    AST_ESCALATE: assert property (
        (st_r.soft_thr != '0 && st_r.leak_cnt >= st_r.soft_thr)
        |=> top_fatal_flag_o)
        else $error("soft fault not escalated");

    AST_AID_SUM: assert property (
        aiding_port_fault_summary_o == (aiding_port_fault_i != 5'h00))
        else $error("aiding port summary wrong");

    AST_NAV_SUM: assert property (
        navigation_fault_summary_o == (navigation_fault_i != 3'h0))
        else $error("navigation summary wrong");

    AST_DATA_SUM: assert property (
        iron_param_fault_i |-> stored_data_fault_summary_o)
        else $error("stored data summary missing iron fault");

    AST_LINK_COND: assert property (
        link_condition_summary_o == (!external_fix_data_i
                                     && st_r.link_mask[0]))
        else $error("link condition summary wrong");

    AST_HW_FAULT: assert property (
        hw_fault_flag_o == (power_fault_summary_i
                            || board_temperature_fault_i))
        else $error("hardware fault flag wrong");

endmodule

`default_nettype wire

// ==== hsa_pkg.sv ====
// Purpose: Constants for the health and status flag aggregator.
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register access.
// Notes:   Register offsets are byte addresses, one aligned word each.
// How it works
// - Board temperature fault is environment bit 0; summary ORs the field.
// - User port summary at link bit 0, aiding at bit 1; flag ORs field.
// - User port faults: tx ovf 0, rx ovf 1, frame 2, break 3, parity 4.
// - User port summary is high exactly while any user port fault bit is set.
// - Aiding port has the same five-bit layout; summary ORs field.
// - Navigation summary at program bit 0, data at bit 1; flag ORs field.
// - Navigation faults: start fail 0, sensor limit 1, deadline miss 2; ORed.
// - Checksum fault at bit 0, iron parameters at bit 1; summary ORs field.
// - Navigation and data faults are instantly fatal; others are soft.
// - HW condition: pulse 0, receiver 1, no differential fix 2, memory 3.
// - Hardware condition summary ORs the field ANDed with its mask.
// - Link condition bit 0 set while no external fix data arrives.
// - Link condition summary ORs the field ANDed with its mask.
// - Program condition: starting 0, gain 1, orientation only 2, yaw turn 3.
// - Program condition summary ORs the field ANDed with its mask.
// - Yaw turn flag set only while yaw rate magnitude exceeds the threshold.
// - Top alert ORs hardware, sensor, link and program condition summaries.
// - Soft faults feed a leaky counter; its threshold latches fatal.
// - Hardware fault flag ORs power and environment fault summaries.

`default_nettype none

package hsa_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_ENV_FAULT   = 8'h00;
    localparam logic [7:0] OFS_LINK_FAULT  = 8'h04;
    localparam logic [7:0] OFS_USER_FAULT  = 8'h08;
    localparam logic [7:0] OFS_AID_FAULT   = 8'h0C;
    localparam logic [7:0] OFS_PROG_FAULT  = 8'h10;
    localparam logic [7:0] OFS_NAV_FAULT   = 8'h14;
    localparam logic [7:0] OFS_DATA_FAULT  = 8'h18;
    localparam logic [7:0] OFS_HW_COND     = 8'h1C;
    localparam logic [7:0] OFS_LINK_COND   = 8'h20;
    localparam logic [7:0] OFS_PROG_COND   = 8'h24;
    localparam logic [7:0] OFS_HW_MASK     = 8'h28;
    localparam logic [7:0] OFS_LINK_MASK   = 8'h2C;
    localparam logic [7:0] OFS_PROG_MASK   = 8'h30;
    localparam logic [7:0] OFS_YAW_THR     = 8'h34;
    localparam logic [7:0] OFS_SOFT_THR    = 8'h38;
    localparam logic [7:0] OFS_CONTROL     = 8'h3C;
    localparam logic [7:0] OFS_HEALTH      = 8'h40;

    // Implemented bits of each 16-bit field
    localparam logic [15:0] VLD_ENV        = 16'h0001;
    localparam logic [15:0] VLD_LINK_FAULT = 16'h0003;
    localparam logic [15:0] VLD_PORT       = 16'h001F;
    localparam logic [15:0] VLD_PROG_FAULT = 16'h0003;
    localparam logic [15:0] VLD_NAV        = 16'h0007;
    localparam logic [15:0] VLD_DATA       = 16'h0003;
    localparam logic [15:0] VLD_HW_COND    = 16'h000F;
    localparam logic [15:0] VLD_LINK_COND  = 16'h0001;
    localparam logic [15:0] VLD_PROG_COND  = 16'h000F;

    // Field bit positions
    localparam int BIT_TEMP        = 0;
    localparam int BIT_USER_PORT   = 0;
    localparam int BIT_AID_PORT    = 1;
    localparam int BIT_NAV_SUM     = 0;
    localparam int BIT_DATA_SUM    = 1;
    localparam int BIT_CHECKSUM    = 0;
    localparam int BIT_IRON        = 1;
    localparam int BIT_MEM_OPEN    = 3;
    localparam int BIT_NO_EXT_FIX  = 0;
    localparam int BIT_STARTING    = 0;
    localparam int BIT_GAIN        = 1;
    localparam int BIT_ORIENT_ONLY = 2;
    localparam int BIT_YAW_TURN    = 3;
    localparam int BIT_CLR_CAL     = 0;
    localparam int BIT_CLR_FATAL   = 1;

    // Top health word positions
    localparam int HW_FATAL      = 0;
    localparam int HW_HWFAULT    = 1;
    localparam int HW_LINKFAULT  = 2;
    localparam int HW_PROGFAULT  = 3;
    localparam int HW_ALERT      = 8;
    localparam int HW_HWCOND     = 9;
    localparam int HW_LINKCOND   = 10;
    localparam int HW_PROGCOND   = 11;
    localparam int HW_SENSCOND   = 12;

    // Reset values
    localparam logic [15:0] RST_HW_MASK   = 16'h0000;
    localparam logic [15:0] RST_LINK_MASK = 16'h0001;
    localparam logic [15:0] RST_PROG_MASK = 16'h0003;
    localparam logic [15:0] RST_YAW_THR   = 16'h0100;
    localparam logic [7:0]  RST_SOFT_THR  = 8'h10;

    // Leak counter
    localparam int          CNT_W     = 8;
    localparam logic [7:0]  SOFT_STEP = 8'h04;
    localparam logic [7:0]  CNT_MAX   = 8'hFF;

    // Timing: leak period
    localparam int CLK_PERIOD_NS  = 8;
    localparam int LEAK_PERIOD_NS = 1000000;
    localparam int LEAK_CYCLES    = LEAK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the health and status aggregator.
// Assumes: Leak tick shortened to 4 cycles; Wishbone answer one cycle.
// Notes:   Ack and read data are taken at the rising edge, before it updates them.
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
 n_mismatch++; $display("Error at %0t: got %0h expected %0h", \
 $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hsa_pkg::*;
    logic        mclk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, hw_condition_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic        board_temperature_fault_i, cal_checksum_mismatch_i;
    logic        cal_write_cmd_i, iron_param_fault_i, external_fix_data_i;
    logic [4:0]  user_port_fault_i, aiding_port_fault_i;
    logic [2:0]  navigation_fault_i;
    logic        navigation_starting_i, gain_level_flag_i;
    logic        orientation_only_tracking_i, power_fault_summary_i;
    logic        sensor_condition_summary_i;
    logic [15:0] yaw_rate_i;
    logic        environment_fault_summary_o, user_port_fault_summary_o;
    logic        aiding_port_fault_summary_o, link_fault_flag_o;
    logic        navigation_fault_summary_o, stored_data_fault_summary_o;
    logic        program_fault_flag_o, hw_fault_flag_o, top_fatal_flag_o;
    logic        hw_condition_summary_o, link_condition_summary_o;
    logic        program_condition_summary_o, top_alert_flag_o;
    logic        soft_fault_o;
    int          n_mismatch = 0;
    int          total_checks = 0;
    hsa_top #(.LEAK_TICK(4)) dut (.*);
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Bus cycle; waits for ack under a bound, data taken at that edge
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [15:0] d);
        int n;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic t_regs;
        wb(OFS_HW_MASK, 0, 0); `CHK(q, 32'h0)
        wb(OFS_PROG_MASK, 0, 0); `CHK(q, 32'h3)
        wb(OFS_SOFT_THR, 0, 0); `CHK(q, 32'(RST_SOFT_THR))
        // Escalation off until the persistence test
        wb(OFS_SOFT_THR, 1, 16'h0000);
        wb(OFS_LINK_MASK, 1, 16'hFFFF);
        wb(OFS_LINK_MASK, 0, 0); `CHK(q, 32'h1)
        wb(OFS_HW_MASK, 1, 16'hFFFF);
        wb(OFS_HW_MASK, 0, 0); `CHK(q, 32'hF)
        wb(OFS_ENV_FAULT, 1, 16'hFFFF);
        wb(OFS_ENV_FAULT, 0, 0); `CHK(q, 32'h0)
        wb(8'hFC, 0, 0); `CHK(q, 32'h0)
        $display("Test registers done");
    endtask
    task automatic t_ports;
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_i);
            user_port_fault_i <= 5'(1 << i);
            aiding_port_fault_i <= 5'(1 << (4 - i));
            #1;
            `CHK(user_port_fault_summary_o, 1'b1)
            `CHK(aiding_port_fault_summary_o, 1'b1)
            `CHK(link_fault_flag_o, 1'b1)
            `CHK(soft_fault_o, 1'b1)
            wb(OFS_USER_FAULT, 0, 0); `CHK(q, 32'(1 << i))
            wb(OFS_AID_FAULT, 0, 0); `CHK(q, 32'(1 << (4 - i)))
            wb(OFS_LINK_FAULT, 0, 0); `CHK(q, 32'h3)
        end
        @(posedge mclk_i);
        user_port_fault_i <= 5'h00;
        board_temperature_fault_i <= 1'b1;
        #1;
        `CHK(user_port_fault_summary_o, 1'b0)
        `CHK(environment_fault_summary_o, 1'b1)
        `CHK(hw_fault_flag_o, 1'b1)
        `CHK(top_fatal_flag_o, 1'b0)
        wb(OFS_ENV_FAULT, 0, 0); `CHK(q, 32'h1)
        @(posedge mclk_i);
        board_temperature_fault_i <= 1'b0;
        aiding_port_fault_i <= 5'h00;
        $display("Test fault leaves done");
    endtask
    task automatic t_program;
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            navigation_fault_i <= 3'(1 << i);
            #1;
            `CHK(top_fatal_flag_o, 1'b1)
            `CHK(program_fault_flag_o, 1'b1)
            `CHK(navigation_fault_summary_o, 1'b1)
            wb(OFS_NAV_FAULT, 0, 0); `CHK(q, 32'(1 << i))
        end
        @(posedge mclk_i);
        navigation_fault_i <= 3'h0;
        iron_param_fault_i <= 1'b1;
        #1;
        `CHK(stored_data_fault_summary_o, 1'b1)
        wb(OFS_PROG_FAULT, 0, 0); `CHK(q, 32'h2)
        iron_param_fault_i <= 1'b0;
        cal_write_cmd_i <= 1'b1;
        @(posedge mclk_i);
        cal_write_cmd_i <= 1'b0;
        wb(OFS_DATA_FAULT, 0, 0); `CHK(q, 32'h1)
        wb(OFS_CONTROL, 1, 16'h0001);
        @(negedge mclk_i);
        `CHK(stored_data_fault_summary_o, 1'b0)
        @(posedge mclk_i);
        cal_checksum_mismatch_i <= 1'b1;
        #1;
        `CHK(stored_data_fault_summary_o, 1'b1)
        `CHK(top_fatal_flag_o, 1'b1)
        @(posedge mclk_i);
        cal_checksum_mismatch_i <= 1'b0;
        $display("Test program faults done");
    endtask
    task automatic t_cond;
        @(posedge mclk_i);
        hw_condition_i <= 4'hB;
        external_fix_data_i <= 1'b0;
        yaw_rate_i <= 16'hFEFF;
        navigation_starting_i <= 1'b1;
        gain_level_flag_i <= 1'b1;
        orientation_only_tracking_i <= 1'b1;
        wb(OFS_HW_MASK, 1, 16'h0004);
        `CHK(hw_condition_summary_o, 1'b0)
        `CHK(link_condition_summary_o, 1'b1)
        `CHK(top_alert_flag_o, 1'b1)
        wb(OFS_PROG_MASK, 1, 16'h0008);
        `CHK(program_condition_summary_o, 1'b1)
        wb(OFS_PROG_COND, 0, 0); `CHK(q, 32'hF)
        wb(OFS_LINK_COND, 0, 0); `CHK(q, 32'h1)
        wb(OFS_HW_COND, 0, 0); `CHK(q, 32'hB)
        external_fix_data_i <= 1'b1;
        yaw_rate_i <= RST_YAW_THR;
        hw_condition_i <= 4'h4;
        #1;
        `CHK(program_condition_summary_o, 1'b0)
        `CHK(hw_condition_summary_o, 1'b1)
        `CHK(link_condition_summary_o, 1'b0)
        @(posedge mclk_i);
        hw_condition_i <= 4'h0;
        sensor_condition_summary_i <= 1'b1;
        #1;
        `CHK(top_alert_flag_o, 1'b1)
        wb(OFS_HEALTH, 0, 0); `CHK(q[12:8], 5'h11)
        $display("Test conditions done");
    endtask
    task automatic t_soft;
        int n;
        // Count left over from the port test must drain first
        repeat (1100) @(posedge mclk_i);
        wb(OFS_SOFT_THR, 1, {8'h00, RST_SOFT_THR});
        wb(OFS_CONTROL, 1, 16'h0002);
        board_temperature_fault_i <= 1'b1;
        #1;
        `CHK(top_fatal_flag_o, 1'b0)
        n = 0;
        while (top_fatal_flag_o !== 1'b1 && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK(n > 8, 1'b1)
        wb(OFS_HEALTH, 0, 0); `CHK(q[1:0], 2'h3)
        $display("Test soft persistence done");
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {board_temperature_fault_i, cal_checksum_mismatch_i} = '0;
        {cal_write_cmd_i, iron_param_fault_i, navigation_fault_i} = '0;
        {user_port_fault_i, aiding_port_fault_i, hw_condition_i} = '0;
        {navigation_starting_i, gain_level_flag_i} = '0;
        {orientation_only_tracking_i, power_fault_summary_i} = '0;
        sensor_condition_summary_i = 1'b0;
        external_fix_data_i = 1'b1;
        yaw_rate_i = 16'h0000;
        wb_sel_i = 4'hF;
        rst_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs();
        t_ports();
        t_program();
        t_cond();
        t_soft();
        close_out();
    end
    // Run needs about 1300 cycles; this allows nearly four times that
    initial begin
        #40000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
